/* serializer_reset_config_regs.sv */
// What this block does
// - auto power-down bit set: power down while no back-channel link is seen.
// - writing 1 to full reset bit resets logic and registers, then self-clears.
// - writing 1 to core reset bit resets logic but keeps registers, self-clears.
// - back-channel crc checker enabled while its configuration bit is one.
// - auto-ack bit makes remote i2c writes acknowledged immediately.
// - pass-through bit enables i2c pass-through mode.
// - pclk auto bit switches to internal oscillator when pixel clock absent.
// - edge select one samples video on rising edge, zero on falling.
`timescale 1ns/1ps
`include "serdes_cfg_defs.svh"

module serializer_reset_config_regs (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire serdes_cfg_pkg::reg_req_t req_i,
    input wire logic back_link_ok_i,
    input wire logic pclk_present_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output serdes_cfg_pkg::cfg_ctrl_t cfg_o,
    output logic power_down_o,
    output logic use_internal_oscillator_o,
    output logic pixel_strobe_rising_o,
    output logic core_reset_o,
    output logic full_reset_o
);
    // ==========================================================
    // input synchronisers for pin-level status
    // both status pins are asynchronous levels from the link and video front ends;
    // each passes two flops before the decode may look at it
    localparam int unsigned SYNC_W = 2;
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] pin_sync;
    logic link_sync;
    logic pclk_sync;

    // bit 0 carries the back-channel link, bit 1 the pixel clock presence
    assign pin_raw = {pclk_present_i, back_link_ok_i};

    for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
        logic s1_r;
        logic s1_nxt;
        logic s2_r;
        logic s2_nxt;

        // first stage follows the pin, second follows the first
        always_comb begin
            s1_nxt = pin_raw[g];
            s2_nxt = s1_r;
        end

        // sync reset clears both stages to the absent level
        always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
                s1_r <= 1'b0;
                s2_r <= 1'b0;
            end else begin
                s1_r <= s1_nxt;
                s2_r <= s2_nxt;
            end
        end

        // only the second stage leaves the loop
        assign pin_sync[g] = s2_r;
    end

    // name the synchronised levels for the decode below
    assign link_sync = pin_sync[0];
    assign pclk_sync = pin_sync[1];

    // ==========================================================
    // digital reset pulse generators
    logic full_req;
    logic core_req;
    logic full_pulse;
    logic core_pulse;

    assign full_req = req_i.wr && (req_i.addr == `RESET_PWR_CTRL_ADDR)
                      && req_i.wdata[`FULL_RST_BIT];
    assign core_req = req_i.wr && (req_i.addr == `RESET_PWR_CTRL_ADDR)
                      && req_i.wdata[`CORE_RST_BIT];

    // one pulse stretcher per self-clearing reset bit
    // a fresh request restarts the count, so repeated writes lengthen the pulse
    logic [1:0] rst_start;
    logic [1:0] rst_pulse;

    assign rst_start = {full_req, core_req};

    for (genvar r = 0; r < 2; r++) begin : g_rst_pulse
        reset_pulse_gen u_pulse (
            .ref_clk_i(ref_clk_i),
            .reset_i(reset_i),
            .start_i(rst_start[r]),
            .pulse_o(rst_pulse[r])
        );
    end

    // bit 1 is the full reset, bit 0 the core reset
    assign full_pulse = rst_pulse[1];
    assign core_pulse = rst_pulse[0];

    // ==========================================================
    // register file
    logic [7:0] rst_reg_r;
    logic [7:0] rst_reg_nxt;
    logic [7:0] cfg0_r;
    logic [7:0] cfg0_nxt;
    logic [7:0] rdata_nxt;
    logic rvalid_nxt;

    // writes merge through masks; reset bits read as pulse state
    always_comb begin
        rst_reg_nxt = rst_reg_r;
        cfg0_nxt = cfg0_r;
        if (full_pulse) begin
            rst_reg_nxt = `RESET_PWR_CTRL_RST;
            cfg0_nxt = `LINK_CFG0_RST;
        end else if (req_i.wr) begin
            if (req_i.addr == `RESET_PWR_CTRL_ADDR) begin
                rst_reg_nxt = (req_i.wdata & `RESET_PWR_CTRL_WMASK)
                              | (`RESET_PWR_CTRL_RST & ~`RESET_PWR_CTRL_WMASK);
            end
            if (req_i.addr == `LINK_CFG0_ADDR) begin
                cfg0_nxt = (req_i.wdata & `LINK_CFG0_WMASK)
                           | (`LINK_CFG0_RST & ~`LINK_CFG0_WMASK);
            end
        end
        // self-clearing reset bits follow the live pulses
        rst_reg_nxt[`FULL_RST_BIT] = full_pulse | full_req;
        rst_reg_nxt[`CORE_RST_BIT] = core_pulse | core_req;
    end

    // register the two bytes; sync reset loads the defaults
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rst_reg_r <= `RESET_PWR_CTRL_RST;
            cfg0_r <= `LINK_CFG0_RST;
        end else begin
            rst_reg_r <= rst_reg_nxt;
            cfg0_r <= cfg0_nxt;
        end
    end

    // ==========================================================
    // read path
    // read data are zero outside a read so the bus idles quietly
    always_comb begin
        rdata_nxt = 8'h00;
        rvalid_nxt = req_i.rd;
        if (req_i.rd) begin
            case (req_i.addr)
                `RESET_PWR_CTRL_ADDR: rdata_nxt = rst_reg_r;
                `LINK_CFG0_ADDR: rdata_nxt = cfg0_r;
                default: rdata_nxt = 8'h00; // unmapped offsets read as zero
            endcase
        end
    end

    // answer stands for exactly one cycle after the taking edge
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rdata_o <= rdata_nxt;
            rvalid_o <= rvalid_nxt;
        end
    end

    // ==========================================================
    // control outputs
    serdes_cfg_pkg::cfg_ctrl_t cfg_nxt;
    logic pdn_nxt;
    logic int_clk_sel_nxt;
    logic strobe_rise_nxt;
    logic core_rst_nxt;
    logic full_rst_nxt;

    // decode fields; core reset clears derived state, not registers
    always_comb begin
        cfg_nxt.auto_power_down = rst_reg_r[`AUTO_PDN_BIT];
        cfg_nxt.crc_check_en = cfg0_r[`CRC_EN_BIT];
        cfg_nxt.remote_auto_ack = cfg0_r[`AUTO_ACK_BIT];
        cfg_nxt.input_filter_en = cfg0_r[`FILTER_EN_BIT];
        cfg_nxt.pass_through_en = cfg0_r[`PASS_THRU_BIT];
        cfg_nxt.pclk_auto_switch = cfg0_r[`PCLK_AUTO_BIT];
        cfg_nxt.pixel_strobe_edge_select = cfg0_r[`EDGE_SEL_BIT];
        // power-down and clock fallback act only on synchronised pin levels
        pdn_nxt = rst_reg_r[`AUTO_PDN_BIT] && !link_sync;
        int_clk_sel_nxt = cfg0_r[`PCLK_AUTO_BIT] && !pclk_sync;
        strobe_rise_nxt = cfg0_r[`EDGE_SEL_BIT];
        // either digital reset holds the derived state at its idle level
        if (core_pulse || full_pulse) begin
            pdn_nxt = 1'b0;
            int_clk_sel_nxt = 1'b0;
        end
        core_rst_nxt = core_pulse | full_pulse;
        full_rst_nxt = full_pulse;
    end

    // outputs straight from flops; reset values match the register defaults
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cfg_o <= serdes_cfg_pkg::cfg_ctrl_t'(`CFG_CTRL_RST);
            power_down_o <= 1'b0;
            use_internal_oscillator_o <= 1'b0;
            pixel_strobe_rising_o <= 1'b0;
            core_reset_o <= 1'b0;
            full_reset_o <= 1'b0;
        end else begin
            cfg_o <= cfg_nxt;
            power_down_o <= pdn_nxt;
            use_internal_oscillator_o <= int_clk_sel_nxt;
            pixel_strobe_rising_o <= strobe_rise_nxt;
            core_reset_o <= core_rst_nxt;
            full_reset_o <= full_rst_nxt;
        end
    end
endmodule // serializer_reset_config_regs

/* serdes_cfg_defs.svh */
`ifndef SERDES_CFG_DEFS_SVH
`define SERDES_CFG_DEFS_SVH

// ==========================================================
// register offsets
`define RESET_PWR_CTRL_ADDR 8'h01
`define LINK_CFG0_ADDR 8'h03

// ==========================================================
// reset values and writable masks
`define RESET_PWR_CTRL_RST 8'h00
`define LINK_CFG0_RST 8'hd2
`define RESET_PWR_CTRL_WMASK 8'h83
`define LINK_CFG0_WMASK 8'hbb
// control word that the register defaults decode to
`define CFG_CTRL_RST 7'h2a

// ==========================================================
// field positions
`define AUTO_PDN_BIT 7
`define FULL_RST_BIT 1
`define CORE_RST_BIT 0
`define CRC_EN_BIT 7
`define AUTO_ACK_BIT 5
`define FILTER_EN_BIT 4
`define PASS_THRU_BIT 3
`define PCLK_AUTO_BIT 1
`define EDGE_SEL_BIT 0

// ==========================================================
// digital reset pulse length in clock cycles
`define DIG_RST_CYCLES 4'h4

`endif

/* serdes_cfg_pkg.sv */
package serdes_cfg_pkg;

    // configuration outputs travelling together
    typedef struct packed {
        logic auto_power_down;
        logic crc_check_en;
        logic remote_auto_ack;
        logic input_filter_en;
        logic pass_through_en;
        logic pclk_auto_switch;
        logic pixel_strobe_edge_select;
    } cfg_ctrl_t;

    // register read or write request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

/* reset_pulse_gen.sv */
`timescale 1ns/1ps
`include "serdes_cfg_defs.svh"

// ==========================================================
// stretches a one-cycle reset request into a fixed pulse
module reset_pulse_gen (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic start_i,
    output logic pulse_o
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;

    // load on request, count down to zero
    always_comb begin
        cnt_nxt = cnt_r;
        if (start_i) begin
            cnt_nxt = `DIG_RST_CYCLES;
        end else if (cnt_r != 4'h0) begin
            cnt_nxt = cnt_r - 4'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign pulse_o = (cnt_r != 4'h0);
endmodule // reset_pulse_gen

/* host_model.sv */
`timescale 1ns/1ps
// ====================
// register host, one strobe per request
module host_model (
    input wire logic ref_clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    output serdes_cfg_pkg::reg_req_t req_o
);
    initial req_o = '0;
    // write strobe held over one taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1 req_o = '{1'b1, 1'b0, a, d};
        @(posedge ref_clk_i);
        #1 req_o = '0;
    endtask
    // read answer stands in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        #1 req_o = '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk_i);
        #1 req_o = '0;
        d = rvalid_i ? rdata_i : 8'hxx;
    endtask
endmodule // host_model

/* serializer_reset_config_properties.sv */
`timescale 1ns/1ps
// ====================
// port checker
module serializer_reset_config_properties (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire serdes_cfg_pkg::reg_req_t req_i,
    input wire logic back_link_ok_i,
    input wire logic pclk_present_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire serdes_cfg_pkg::cfg_ctrl_t cfg_o,
    input wire logic power_down_o,
    input wire logic use_internal_oscillator_o,
    input wire logic pixel_strobe_rising_o,
    input wire logic core_reset_o,
    input wire logic full_reset_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // reset writes to the reset register
    sequence s_full_wr; req_i.wr && req_i.addr == 8'h01 && req_i.wdata[1]; endsequence
    sequence s_core_wr; req_i.wr && req_i.addr == 8'h01 && req_i.wdata[0]; endsequence
    property p_rd; req_i.rd |=> rvalid_o; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_unmap; req_i.rd && !(req_i.addr inside {8'h01, 8'h03}) |=> rdata_o == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_pdn_on;
        (cfg_o.auto_power_down && !back_link_ok_i && !core_reset_o && !req_i.wr) [*4]
            |=> power_down_o;
    endproperty
    a_pdn_on: assert property (p_pdn_on) else $error("no power down");
    property p_pdn_off; (!cfg_o.auto_power_down) [*4] |-> !power_down_o; endproperty
    a_pdn_off: assert property (p_pdn_off) else $error("power down while off");
    property p_int_clk;
        (cfg_o.pclk_auto_switch && !pclk_present_i && !core_reset_o && !req_i.wr) [*4]
            |=> use_internal_oscillator_o;
    endproperty
    a_int_clk: assert property (p_int_clk) else $error("no oscillator switch");
    property p_edge; $stable(cfg_o) [*3] |-> pixel_strobe_rising_o == cfg_o[0]; endproperty
    a_edge: assert property (p_edge) else $error("strobe edge wrong");
    property p_full; s_full_wr ##0 !core_reset_o |-> ##[1:3] full_reset_o [*3]; endproperty
    a_full: assert property (p_full) else $error("full reset missing");
    property p_full_end; $fell(full_reset_o) |-> cfg_o == 7'h2a; endproperty
    a_full_end: assert property (p_full_end) else $error("registers kept");
    property p_core; s_core_wr ##0 !core_reset_o |-> ##[1:3] core_reset_o ##1 $stable(cfg_o);
    endproperty
    a_core: assert property (p_core) else $error("core reset wrong");
endmodule // serializer_reset_config_properties

bind serializer_reset_config_regs serializer_reset_config_properties chk_u (.ref_clk_i,
    .reset_i, .req_i, .back_link_ok_i, .pclk_present_i, .rdata_o, .rvalid_o, .cfg_o,
    .power_down_o, .use_internal_oscillator_o, .pixel_strobe_rising_o, .core_reset_o,
    .full_reset_o);

/* tb_top.sv */
`timescale 1ns/1ps
// ====================
// bench top
module tb_top;
    logic ref_clk_i, reset_i, back_link_ok_i, pclk_present_i, rvalid_o, power_down_o;
    logic use_internal_oscillator_o, pixel_strobe_rising_o, core_reset_o, full_reset_o;
    logic [7:0] rdata_o;
    serdes_cfg_pkg::reg_req_t req_i;
    serdes_cfg_pkg::cfg_ctrl_t cfg_o;
    int err_count, comparisons;
    serializer_reset_config_regs dut_u (.ref_clk_i, .reset_i, .req_i, .back_link_ok_i,
        .pclk_present_i, .rdata_o, .rvalid_o, .cfg_o, .power_down_o,
        .use_internal_oscillator_o, .pixel_strobe_rising_o, .core_reset_o, .full_reset_o);
    host_model host_u (.ref_clk_i, .rdata_i(rdata_o), .rvalid_i(rvalid_o), .req_o(req_i));
    // free running clock
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host_u.rd(a, d);
        chk(n, e, d);
    endtask
    // bounded wait for the digital reset level
    task automatic wait_core(input logic want);
        int k;
        k = 0;
        while (core_reset_o !== want && k < 20) begin
            @(posedge ref_clk_i);
            #2 k++;
        end
        if (core_reset_o !== want) begin
            err_count++;
            end_of_test();
        end
    endtask
    task automatic settle;
        repeat (5) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic t_fields;
        host_u.wr(8'h03, 8'hff);
        rdchk("cfg0 set", 8'h03, 8'hfb);
        chk("cfg set", 8'h3f, {1'b0, cfg_o});
        chk("edge rise", 8'h01, {7'h00, pixel_strobe_rising_o});
        host_u.wr(8'h03, 8'h00);
        rdchk("cfg0 clear", 8'h03, 8'h40);
        chk("cfg clear", 8'h00, {1'b0, cfg_o});
        host_u.wr(8'h02, 8'hff);
        rdchk("unmapped", 8'h02, 8'h00);
    endtask
    task automatic t_link;
        host_u.wr(8'h01, 8'h80);
        host_u.wr(8'h03, 8'h02);
        back_link_ok_i = 1'b0;
        pclk_present_i = 1'b0;
        settle();
        chk("pdn", 8'h01, {7'h00, power_down_o});
        chk("int clk", 8'h01, {7'h00, use_internal_oscillator_o});
        back_link_ok_i = 1'b1;
        pclk_present_i = 1'b1;
        settle();
        chk("pdn link", 8'h00, {7'h00, power_down_o});
        chk("int clk back", 8'h00, {7'h00, use_internal_oscillator_o});
    endtask
    task automatic t_resets;
        host_u.wr(8'h03, 8'h0b);
        host_u.wr(8'h01, 8'h81);
        wait_core(1'b1);
        chk("core only", 8'h00, {7'h00, full_reset_o});
        wait_core(1'b0);
        rdchk("core keeps", 8'h03, 8'h4b);
        rdchk("core clears", 8'h01, 8'h80);
        host_u.wr(8'h01, 8'h02);
        wait_core(1'b1);
        chk("full flag", 8'h01, {7'h00, full_reset_o});
        host_u.wr(8'h03, 8'h0b);
        wait_core(1'b0);
        rdchk("full cfg0", 8'h03, 8'hd2);
        rdchk("full reg", 8'h01, 8'h00);
    endtask
    // reset, then the scenarios in turn
    initial begin
        reset_i = 1'b1;
        back_link_ok_i = 1'b1;
        pclk_present_i = 1'b1;
        repeat (8) @(posedge ref_clk_i);
        #1 reset_i = 1'b0;
        chk("cfg rst", 8'h2a, {1'b0, cfg_o});
        rdchk("rst reg", 8'h01, 8'h00);
        rdchk("rst cfg0", 8'h03, 8'hd2);
        t_fields();
        t_link();
        t_resets();
        end_of_test();
    end
endmodule // tb_top
